/* File: design/bxs_pkg.sv */
package bxs_pkg;

	localparam int ADDR_W = 20;
	localparam int A2_BIT = 2;

	// Level of the direction output for each way of data flow.
	localparam logic DIR_RECEIVE  = 1'b0;
	localparam logic DIR_TRANSMIT = 1'b1;

	// Reset values of the pin outputs.
	localparam logic SEL_RST     = 1'b1;
	localparam logic DEN_RST     = 1'b1;
	localparam logic DEN_OE_RST  = 1'b1;
	localparam logic DIR_RST     = 1'b0;
	localparam logic DIR_OE_RST  = 1'b0;
	localparam logic GRANT_RST   = 1'b0;

	// Clocks for which the enable is driven high in reset before floating.
	localparam int RST_DRIVE_CLKS = 1;
	localparam int CLK_PERIOD_NS  = 100;

	typedef struct packed {
		logic              req;
		logic              write;
		logic              io;
		logic [ADDR_W-1:0] addr;
	} bxs_cyc_type;

	typedef struct packed {
		logic              as_addr;
		logic              space_io;
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] limit;
	} bxs_selcfg_type;

	typedef struct packed {
		logic dir;
		logic dir_oe;
		logic den_b;
		logic den_oe;
	} bxs_xcvr_type;

	typedef enum logic [5:0] {
		ST_RST_DRIVE = 6'h01,
		ST_RST_FLOAT = 6'h02,
		ST_IDLE      = 6'h04,
		ST_TURN      = 6'h08,
		ST_ACTIVE    = 6'h10,
		ST_HOLD      = 6'h20
	} bxs_state_type;

endpackage

/* File: design/bxs_sel_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module bxs_sel_unit (
	input  wire bxs_pkg::bxs_cyc_type    cyc,      // Current cycle request
	input  wire bxs_pkg::bxs_selcfg_type cfg,      // Select configuration
	input  wire logic                    a2_held,  // Latched address bit
	output logic                         sel_b     // Next select pin level
);
	import bxs_pkg::*;

	logic hit;

	// The range is inclusive at both ends and the space must match.
	assign hit = cyc.req && (cyc.io == cfg.space_io) &&
		(cyc.addr >= cfg.base) && (cyc.addr <= cfg.limit);

	always_comb begin
		if (cfg.as_addr) begin
			sel_b = a2_held;
		end else begin
			sel_b = ~hit;
		end
	end
endmodule
`default_nettype wire

/* File: design/bxs_bus_xcvr_ctrl.sv */
// Notes on behaviour
// - Shared select pin acts as seventh chip select or latched address bit two.
// - As chip select it goes low only for accesses inside the programmed range.
// - In address mode the pin keeps its last latched bit during bus grant.
// - Direction is low when data flows in, high when writing data out.
// - Transceiver enable is low during every memory and I/O access.
// - Transceiver enable is high whenever the direction output changes.
// - In reset the enable is driven high one clock, then floated.
// - On hold acknowledge the direction and enable outputs are floated.
`timescale 1ns/1ps
`default_nettype none
module bxs_bus_xcvr_ctrl (
	input  wire logic                    clk,       // 10 MHz clock
	input  wire logic                    rst_b,     // Asynchronous reset
	input  wire logic                    core_rst,  // Processor reset level
	input  wire logic                    hold_req,  // Hold request pin
	input  wire bxs_pkg::bxs_cyc_type    cyc,       // Cycle from the core
	input  wire bxs_pkg::bxs_selcfg_type sel_cfg,   // Select configuration
	output logic                         cyc_go,    // Cycle started pulse
	output logic                         bus_grant_ack, // Hold acknowledge
	output bxs_pkg::bxs_xcvr_type        xcvr,      // Transceiver pins
	output logic                         periph_select_seven_or_address_two
	                                                // Shared select pin
);
	import bxs_pkg::*;

	bxs_state_type state_q;
	bxs_state_type state_d;
	logic          hold_s1_q;
	logic          hold_s2_q;
	logic          hold_s3_q;
	logic          hold_q;
	logic          a2_q;
	logic          dir_q;
	logic          dir_oe_q;
	logic          den_q;
	logic          den_oe_q;
	logic          sel_q;
	logic          grant_q;
	logic          go_q;
	logic          sel_d;
	logic          start;
	localparam int DRV_W = 4;
	logic [DRV_W-1:0] drv_cnt_q;
	logic             drv_done;

	// Hold pin synchroniser; a change counts once stages two and three agree.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_s1_q <= 1'b0;
			hold_s2_q <= 1'b0;
			hold_s3_q <= 1'b0;
		end else begin
			hold_s1_q <= hold_req;
			hold_s2_q <= hold_s1_q;
			hold_s3_q <= hold_s2_q;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_q <= 1'b0;
		end else if (hold_s2_q == hold_s3_q) begin
			hold_q <= hold_s3_q;
		end
	end

	// A new access begins from idle or directly after a turnaround.
	assign start = (state_q == ST_IDLE && !hold_q && cyc.req &&
		cyc.write == dir_q) || (state_q == ST_TURN);

	// Counts driven-high enable clocks in reset before the enable floats.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			drv_cnt_q <= '0;
		end else if (state_q != ST_RST_DRIVE) begin
			drv_cnt_q <= '0;
		end else if (!drv_done) begin
			drv_cnt_q <= drv_cnt_q + 1'b1;
		end
	end

	assign drv_done = (drv_cnt_q == DRV_W'(RST_DRIVE_CLKS - 1));

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RST_DRIVE: begin
				if (!core_rst) begin
					state_d = ST_IDLE;
				end else if (drv_done) begin
					state_d = ST_RST_FLOAT;
				end
			end
			ST_RST_FLOAT: begin
				if (!core_rst) begin
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (core_rst) begin
					state_d = ST_RST_DRIVE;
				end else if (hold_q) begin
					state_d = ST_HOLD;
				end else if (cyc.req && cyc.write != dir_q) begin
					state_d = ST_TURN;
				end else if (cyc.req) begin
					state_d = ST_ACTIVE;
				end
			end
			ST_TURN: begin
				state_d = ST_ACTIVE;
			end
			ST_ACTIVE: begin
				if (core_rst) begin
					state_d = ST_RST_DRIVE;
				end else if (!cyc.req) begin
					state_d = ST_IDLE;
				end
			end
			ST_HOLD: begin
				if (core_rst) begin
					state_d = ST_RST_DRIVE;
				end else if (!hold_q) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_RST_DRIVE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_RST_DRIVE;
		end else begin
			state_q <= state_d;
		end
	end

	// Direction only moves on entry to a turnaround, when enable is high.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dir_q    <= DIR_RST;
			dir_oe_q <= DIR_OE_RST;
		end else begin
			if (state_q == ST_IDLE && state_d == ST_TURN) begin
				dir_q <= cyc.write ? DIR_TRANSMIT : DIR_RECEIVE;
			end
			case (state_d)
				ST_IDLE, ST_TURN, ST_ACTIVE: dir_oe_q <= 1'b1;
				default:                     dir_oe_q <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			den_q    <= DEN_RST;
			den_oe_q <= DEN_OE_RST;
		end else begin
			case (state_d)
				ST_ACTIVE: begin
					den_q    <= 1'b0;
					den_oe_q <= 1'b1;
				end
				ST_IDLE, ST_TURN, ST_RST_DRIVE: begin
					den_q    <= 1'b1;
					den_oe_q <= 1'b1;
				end
				default: begin
					den_q    <= 1'b1;
					den_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// Address bit two is caught only when an access starts.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			a2_q <= 1'b0;
		end else if (start) begin
			a2_q <= cyc.addr[A2_BIT];
		end
	end

	bxs_sel_unit i_bxs_sel_unit (
		.cyc     (cyc),
		.cfg     (sel_cfg),
		.a2_held (a2_q),
		.sel_b   (sel_d)
	);

	// The select pin has no enable: it is driven in every state.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_q <= SEL_RST;
		end else if (sel_cfg.as_addr) begin
			sel_q <= sel_d;
		end else if (state_d == ST_ACTIVE) begin
			sel_q <= sel_d;
		end else begin
			sel_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			grant_q <= GRANT_RST;
			go_q    <= 1'b0;
		end else begin
			grant_q <= (state_d == ST_HOLD);
			go_q    <= start;
		end
	end

	assign cyc_go                             = go_q;
	assign bus_grant_ack                      = grant_q;
	assign xcvr.dir                           = dir_q;
	assign xcvr.dir_oe                        = dir_oe_q;
	assign xcvr.den_b                         = den_q;
	assign xcvr.den_oe                        = den_oe_q;
	assign periph_select_seven_or_address_two = sel_q;
endmodule
`default_nettype wire

/* File: test/bxs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module bxs_checker (
	input wire logic                    clk,           // Clock
	input wire logic                    rst_b,         // Reset
	input wire logic                    core_rst,      // Core reset
	input wire logic                    hold_req,      // Hold
	input wire bxs_pkg::bxs_cyc_type    cyc,           // Cycle
	input wire bxs_pkg::bxs_selcfg_type sel_cfg,       // Config
	input wire logic                    cyc_go,        // Start
	input wire logic                    bus_grant_ack, // Grant
	input wire bxs_pkg::bxs_xcvr_type   xcvr,          // Pins
	input wire logic periph_select_seven_or_address_two // Select
);
	import bxs_pkg::*;
	wire psel;
	wire hit;
	assign psel = periph_select_seven_or_address_two;
	assign hit = cyc.req && cyc.io == sel_cfg.space_io &&
		cyc.addr >= sel_cfg.base && cyc.addr <= sel_cfg.limit;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_SEL_HOLD: assert property (
		bus_grant_ack && $past(bus_grant_ack) |-> $stable(psel))
		else $error("select moved in grant");
	AST_DEN_TURN: assert property (
		!$stable(xcvr.dir) |-> xcvr.den_b && $past(xcvr.den_b))
		else $error("enable low on turn");
	AST_GRANT_FLOAT: assert property (
		bus_grant_ack |-> !xcvr.dir_oe && !xcvr.den_oe)
		else $error("driven in grant");
	AST_DEN_GO: assert property (
		cyc_go |-> !xcvr.den_b && xcvr.den_oe)
		else $error("enable off in access");
	AST_DIR_WR: assert property (
		cyc_go |-> xcvr.dir == cyc.write)
		else $error("wrong direction");
	AST_RST_ONE: assert property (
		$rose(core_rst) |=> xcvr.den_oe && xcvr.den_b ##1 !xcvr.den_oe)
		else $error("enable reset drive");
	AST_CS_RANGE: assert property (
		cyc_go && !sel_cfg.as_addr |-> psel == !hit)
		else $error("select decode");
	AST_A2_GO: assert property (
		cyc_go && sel_cfg.as_addr |=> psel == $past(cyc.addr[A2_BIT], 2))
		else $error("address bit");
	cover property (cyc_go && xcvr.dir);
	cover property (bus_grant_ack);
	cover property ($rose(core_rst));
endmodule
bind bxs_bus_xcvr_ctrl bxs_checker i_bxs_checker (.clk, .rst_b,
	.core_rst, .hold_req, .cyc, .sel_cfg, .cyc_go, .bus_grant_ack,
	.xcvr, .periph_select_seven_or_address_two);
`default_nettype wire

/* File: test/bxs_xcvr_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bxs_xcvr_model (
	input wire logic                  clk,     // Clock
	input wire bxs_pkg::bxs_xcvr_type xcvr,    // Controller pins
	output logic                      to_bus,  // Driving data out
	output logic                      from_bus // Driving data in
);
	import bxs_pkg::*;
	logic last_q;
	logic dir_w;
	logic den_w;
	always_ff @(posedge clk) begin
		if (xcvr.dir_oe)
			last_q <= xcvr.dir;
	end
	// A floated direction line wanders; the enable has a board pull-up.
	assign dir_w = xcvr.dir_oe ? xcvr.dir : ~last_q;
	assign den_w = xcvr.den_oe ? xcvr.den_b : 1'b1;
	assign to_bus = !den_w && dir_w;
	assign from_bus = !den_w && !dir_w;
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bxs_pkg::*;
	logic           clk = 1'b0;
	logic           rst_b = 1'b0;
	logic           core_rst = 1'b0;
	logic           hold_req = 1'b0;
	bxs_cyc_type    cy = '0;
	bxs_selcfg_type cf = '0;
	bxs_xcvr_type   xc;
	logic           cyc_go;
	logic           grant;
	logic           sel;
	logic           to_bus;
	logic           from_bus;
	int             n_errors = 0;
	int             num_checks = 0;
	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	bxs_bus_xcvr_ctrl i_bxs_bus_xcvr_ctrl (.clk(clk), .rst_b(rst_b),
		.core_rst(core_rst), .hold_req(hold_req), .cyc(cy),
		.sel_cfg(cf), .cyc_go(cyc_go), .bus_grant_ack(grant),
		.xcvr(xc), .periph_select_seven_or_address_two(sel));
	bxs_xcvr_model i_bxs_xcvr_model (.clk(clk), .xcvr(xc),
		.to_bus(to_bus), .from_bus(from_bus));
	task automatic chk(input logic [3:0] g, input logic [3:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic io,
		input logic [19:0] a, input logic s);
		int k;
		cy = '{1'b1, w, io, a};
		k = 0;
		while (cyc_go !== 1'b1 && k < 20) begin
			@(negedge clk);
			k++;
		end
		chk(cyc_go, 1'b1);
		chk({xc.dir, xc.den_b}, {w, 1'b0});
		if (!cf.as_addr)
			chk(sel, s);
		chk({to_bus, from_bus}, {w, !w});
		@(negedge clk);
		chk(sel, s);
		cy.req = 1'b0;
		repeat (3) @(negedge clk);
		chk({xc.den_b, sel}, {1'b1, cf.as_addr ? a[2] : 1'b1});
	endtask
	task automatic t_hold(input logic s);
		int k;
		hold_req = 1'b1;
		k = 0;
		while (grant !== 1'b1 && k < 20) begin
			@(negedge clk);
			k++;
		end
		chk(grant, 1'b1);
		repeat (4) @(negedge clk);
		chk({grant, xc.dir_oe, xc.den_oe}, 4'h4);
		chk({to_bus, from_bus, sel}, {2'h0, s});
		hold_req = 1'b0;
		repeat (8) @(negedge clk);
		chk({grant, xc.den_oe, xc.den_b}, 4'h3);
	endtask
	task automatic t_cs();
		cf = '{1'b0, 1'b1, 20'h00100, 20'h001ff};
		acc(1'b0, 1'b1, 20'h00100, 1'b0);
		acc(1'b1, 1'b1, 20'h001ff, 1'b0);
		acc(1'b0, 1'b1, 20'h00200, 1'b1);
		acc(1'b0, 1'b0, 20'h00150, 1'b1);
		acc(1'b1, 1'b1, 20'h000ff, 1'b1);
		cf.space_io = 1'b0;
		acc(1'b0, 1'b0, 20'h00150, 1'b0);
		t_hold(1'b1);
	endtask
	task automatic t_rst();
		core_rst = 1'b1;
		@(negedge clk);
		chk({xc.den_oe, xc.den_b, xc.dir_oe}, 4'h6);
		repeat (4) @(negedge clk);
		chk(xc.den_oe, 1'b0);
		core_rst = 1'b0;
		repeat (2) @(negedge clk);
		chk({xc.den_oe, xc.den_b}, 4'h3);
	endtask
	task automatic t_a2();
		cf.as_addr = 1'b1;
		acc(1'b0, 1'b0, 20'h00004, 1'b1);
		acc(1'b1, 1'b0, 20'h00008, 1'b0);
		t_hold(1'b0);
	endtask
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		t_cs();
		t_rst();
		t_a2();
		end_of_test();
	end
	initial begin
		#(CLK_PERIOD_NS * 2000);
		n_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
